// File: rtl/smp_pkg.sv
// Package of constants and carrier types for the synchronous memory port
// Functional notes
// - Read latency zero to three port clocks
// - Write latency zero to three port clocks
// - Extension off: chip enable drops after last command
// - Extension on: chip enable follows output enable
// - Mode zero: strobe is address strobe, deselects
// - Mode one: strobe is read enable, no deselects
// - Transfers follow output clock one or two
// - Hold: clocks with tristate bit zero keep toggling
// - Hold: clocks with tristate bit one float
// - Finish pending transfers before acknowledging hold
// - Hold disable ignores requests, withholds acknowledge
// - Narrow address pins carry boot straps in reset
// - Port clock from pin, CPU/4 or CPU/6
// - Wide port 64 bits, narrow port 16 bits
package smp_pkg;
   localparam int WIDE_DATA_W = 64;
   localparam int WIDE_BE_W = 8;
   localparam int WIDE_ADDR_W = 20;
   localparam int NARROW_DATA_W = 16;
   localparam int NARROW_BE_W = 2;
   localparam int NARROW_ADDR_W = 20;
   localparam int SPACES = 4;
   localparam int DIV_FOUR = 4;
   localparam int DIV_SIX = 6;
   localparam int DIV_CNT_W = 3;
   localparam int STRAP_W = 12;
   localparam logic [1:0] CLK_SRC_PIN = 2'h0;
   localparam logic [1:0] CLK_SRC_DIV4 = 2'h1;
   localparam logic [1:0] CLK_SRC_DIV6 = 2'h2;
   localparam logic [1:0] LAT_RESET = 2'h0;

   // Per-space secondary control fields
   typedef struct packed {
      logic [1:0] sync_read_latency;
      logic [1:0] sync_write_latency;
      logic chip_enable_extend;
      logic read_enable_mode;
      logic sync_clock_select;
   } smp_sec_ctrl_s;

   // Global control bits
   typedef struct packed {
      logic [1:0] out_clock_hold_tristate;
      logic hold_disable;
      logic [1:0] clk_src;
   } smp_glb_ctrl_s;

   // Access request from the user side
   typedef struct packed {
      logic write;
      logic [1:0] space;
      logic [WIDE_ADDR_W-1:0] addr;
      logic [WIDE_BE_W-1:0] byte_en;
      logic [WIDE_DATA_W-1:0] wdata;
   } smp_req_s;

   typedef enum logic [2:0] {
      SMP_IDLE = 3'h0,
      SMP_CMD = 3'h1,
      SMP_LAT = 3'h3,
      SMP_DATA = 3'h2,
      SMP_DESEL = 3'h6,
      SMP_HOLD = 3'h7
   } smp_state_e;
endpackage

// File: rtl/smp_clk_gen.sv
// Port clock enable generator and output clock pair
module smp_clk_gen (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [1:0] clk_src,
   input wire logic mem_in_clock,
   output logic port_tick,
   output logic mem_out_clock_one,
   output logic mem_out_clock_two
);
   logic in_meta; // First sync stage, read only by in_sync
   logic in_sync;
   logic in_last;
   logic [2:0] div_cnt;
   logic half;

   // Synchronise the pin clock
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         in_meta <= 1'b0;
         in_sync <= 1'b0;
         in_last <= 1'b0;
      end else begin
         in_meta <= mem_in_clock;
         in_sync <= in_meta;
         in_last <= in_sync;
      end
   end

   // Divider and tick select
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         div_cnt <= 3'h0;
         port_tick <= 1'b0;
      end else begin
         port_tick <= 1'b0;
         case (clk_src)
            smp_pkg::CLK_SRC_DIV4, smp_pkg::CLK_SRC_DIV6: begin
               if (div_cnt == ((clk_src == smp_pkg::CLK_SRC_DIV4) ?
                   3'(smp_pkg::DIV_FOUR - 1) : 3'(smp_pkg::DIV_SIX - 1))) begin
                  div_cnt <= 3'h0;
                  port_tick <= 1'b1;
               end else begin
                  div_cnt <= div_cnt + 3'h1;
               end
            end
            default: begin
               div_cnt <= 3'h0;
               port_tick <= in_sync & ~in_last;
            end
         endcase
      end
   end

   // Clock one toggles each tick, clock two at half that rate
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mem_out_clock_one <= 1'b0;
         mem_out_clock_two <= 1'b0;
         half <= 1'b0;
      end else if (port_tick) begin
         mem_out_clock_one <= ~mem_out_clock_one;
         half <= ~half;
         if (half) begin
            mem_out_clock_two <= ~mem_out_clock_two;
         end
      end
   end
endmodule

// File: rtl/smp_port.sv
// Synchronous memory port with bus hold handshake
module smp_port (
   input wire logic clock,
   input wire logic rst_b,
   input wire smp_pkg::smp_glb_ctrl_s glb,
   input wire smp_pkg::smp_sec_ctrl_s [smp_pkg::SPACES-1:0] sec,
   input wire logic mem_in_clock,
   input wire logic req_valid,
   input wire smp_pkg::smp_req_s req,
   output logic req_ready,
   output logic rd_valid,
   output logic [smp_pkg::WIDE_DATA_W-1:0] rd_data,
   input wire logic hold_req_b,
   output logic bus_hold_ack_b,
   output logic busy,
   input wire logic [smp_pkg::WIDE_DATA_W-1:0] wide_port_data_in,
   output logic [smp_pkg::WIDE_DATA_W-1:0] wide_port_data_out,
   output logic wide_port_data_oe,
   output logic [smp_pkg::WIDE_ADDR_W-1:0] wide_port_addr,
   output logic [smp_pkg::WIDE_BE_W-1:0] wide_port_byte_en_b,
   output logic [smp_pkg::SPACES-1:0] space_chip_enable_b,
   output logic sync_address_strobe_b,
   output logic sync_output_enable_b,
   output logic sync_write_enable_b,
   output logic mem_bus_oe,
   output logic [1:0] mem_out_clock,
   output logic [1:0] mem_out_clock_oe,
   input wire logic [smp_pkg::NARROW_ADDR_W-1:0] narrow_port_addr_in,
   output logic [smp_pkg::STRAP_W-1:0] boot_config
);
   ///////////////////////////////////////////////////////////////////////
   logic tick; // Port clock enable
   logic clk_one;
   logic clk_two;
   logic clk_one_d;
   logic clk_two_d;
   logic edge_sel; // Rising edge of the selected output clock
   smp_pkg::smp_state_e state;
   smp_pkg::smp_req_s cur; // Captured request
   smp_pkg::smp_sec_ctrl_s cfg; // Captured space settings
   logic [1:0] lat_cnt;
   logic hold_meta; // First sync stage
   logic hold_sync;
   logic rst_seen;
   logic [smp_pkg::STRAP_W-1:0] strap_meta;

   smp_clk_gen u_clk (
      .clock(clock),
      .rst_b(rst_b),
      .clk_src(glb.clk_src),
      .mem_in_clock(mem_in_clock),
      .port_tick(tick),
      .mem_out_clock_one(clk_one),
      .mem_out_clock_two(clk_two)
   );

   ///////////////////////////////////////////////////////////////////////
   // Edge of chosen output clock paces transfers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         clk_one_d <= 1'b0;
         clk_two_d <= 1'b0;
      end else begin
         clk_one_d <= clk_one;
         clk_two_d <= clk_two;
      end
   end
   assign edge_sel = cfg.sync_clock_select ? (clk_two & ~clk_two_d)
                                           : (clk_one & ~clk_one_d);

   // Synchronise the hold request pin
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hold_meta <= 1'b0;
         hold_sync <= 1'b0;
      end else begin
         hold_meta <= ~hold_req_b;
         hold_sync <= hold_meta;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Transfer sequencer and hold arbitration
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= smp_pkg::SMP_IDLE;
         cur <= '0;
         cfg <= '0;
         lat_cnt <= smp_pkg::LAT_RESET;
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         case (state)
            smp_pkg::SMP_IDLE: begin
               // Hold taken only between transfers
               if (hold_sync && !glb.hold_disable) begin
                  state <= smp_pkg::SMP_HOLD;
               end else if (req_valid && !req_ready) begin
                  cur <= req;
                  cfg <= sec[req.space];
                  req_ready <= 1'b1;
                  state <= smp_pkg::SMP_CMD;
               end
            end
            smp_pkg::SMP_CMD: begin
               if (edge_sel) begin
                  // Latency from the space setting
                  lat_cnt <= cur.write ? cfg.sync_write_latency
                                       : cfg.sync_read_latency;
                  state <= smp_pkg::SMP_LAT;
               end
            end
            smp_pkg::SMP_LAT: begin
               if (edge_sel) begin
                  if (lat_cnt == 2'h0) begin
                     state <= smp_pkg::SMP_DATA;
                  end else begin
                     lat_cnt <= lat_cnt - 2'h1;
                  end
               end
            end
            smp_pkg::SMP_DATA: begin
               if (edge_sel) begin
                  if (!cur.write) begin
                     rd_data <= wide_port_data_in;
                     rd_valid <= 1'b1;
                  end
                  // Deselect only in strobe mode
                  state <= cfg.read_enable_mode ? smp_pkg::SMP_IDLE
                                                : smp_pkg::SMP_DESEL;
               end
            end
            smp_pkg::SMP_DESEL: begin
               if (edge_sel) begin
                  state <= smp_pkg::SMP_IDLE;
               end
            end
            smp_pkg::SMP_HOLD: begin
               if (!hold_sync || glb.hold_disable) begin
                  state <= smp_pkg::SMP_IDLE;
               end
            end
            default: begin
               state <= smp_pkg::SMP_IDLE;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Pin drive from the sequencer state
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         space_chip_enable_b <= '1;
         sync_address_strobe_b <= 1'b1;
         sync_output_enable_b <= 1'b1;
         sync_write_enable_b <= 1'b1;
         wide_port_addr <= '0;
         wide_port_byte_en_b <= '1;
         wide_port_data_out <= '0;
         wide_port_data_oe <= 1'b0;
         mem_bus_oe <= 1'b0;
         bus_hold_ack_b <= 1'b1;
         busy <= 1'b0;
      end else begin
         busy <= (state != smp_pkg::SMP_IDLE) &&
                 (state != smp_pkg::SMP_HOLD);
         bus_hold_ack_b <= ~(state == smp_pkg::SMP_HOLD);
         mem_bus_oe <= (state != smp_pkg::SMP_HOLD);
         wide_port_addr <= cur.addr;
         wide_port_byte_en_b <= (state == smp_pkg::SMP_IDLE) ?
                                '1 : ~cur.byte_en;
         wide_port_data_out <= cur.wdata;
         wide_port_data_oe <= cur.write && (state == smp_pkg::SMP_DATA);
         sync_write_enable_b <= ~(cur.write &&
                                  (state == smp_pkg::SMP_CMD));
         // Strobe: address strobe on command or read enable on data
         if (cfg.read_enable_mode) begin
            sync_address_strobe_b <= ~(!cur.write &&
                                       (state == smp_pkg::SMP_DATA));
         end else begin
            sync_address_strobe_b <= ~(state == smp_pkg::SMP_CMD);
         end
         sync_output_enable_b <= ~(!cur.write &&
             ((state == smp_pkg::SMP_LAT) || (state == smp_pkg::SMP_DATA)));
         space_chip_enable_b <= '1;
         if (cfg.chip_enable_extend) begin
            // Chip enable tracks output enable
            if (!cur.write && ((state == smp_pkg::SMP_LAT) ||
                (state == smp_pkg::SMP_DATA))) begin
               space_chip_enable_b[cur.space] <= 1'b0;
            end else if (state == smp_pkg::SMP_CMD) begin
               space_chip_enable_b[cur.space] <= 1'b0;
            end
         end else if (state == smp_pkg::SMP_CMD) begin
            // Drop after the command is issued
            space_chip_enable_b[cur.space] <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Output clocks, floated in hold per tristate bit
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mem_out_clock <= 2'h0;
         mem_out_clock_oe <= 2'h0;
      end else begin
         mem_out_clock <= {clk_two, clk_one};
         for (int i = 0; i < 2; i++) begin
            mem_out_clock_oe[i] <= !((state == smp_pkg::SMP_HOLD) &&
                                     glb.out_clock_hold_tristate[i]);
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Boot straps from narrow address pins, caught while in reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rst_seen <= 1'b1;
      end else begin
         rst_seen <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      strap_meta <= {narrow_port_addr_in[20-1:12], narrow_port_addr_in[10],
                     narrow_port_addr_in[8:6]};
      if (rst_seen) begin
         boot_config <= strap_meta;
      end
   end
endmodule

// File: bench/smp_port_monitor.sv
// Concurrent checks on the pins of the synchronous memory port
module smp_port_monitor (
   input wire logic clock,
   input wire logic rst_b,
   input wire smp_pkg::smp_glb_ctrl_s glb,
   input wire logic req_ready,
   input wire logic busy,
   input wire logic bus_hold_ack_b,
   input wire logic wide_port_data_oe,
   input wire logic [smp_pkg::SPACES-1:0] space_chip_enable_b,
   input wire logic mem_bus_oe,
   input wire logic [1:0] mem_out_clock,
   input wire logic [1:0] mem_out_clock_oe,
   input wire logic [smp_pkg::NARROW_ADDR_W-1:0] narrow_port_addr_in,
   input wire logic [smp_pkg::STRAP_W-1:0] boot_config
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // Hold has been granted for two edges in a row
   sequence s_held;
      !bus_hold_ack_b [*2];
   endsequence
   // Port idle and bus owned for three edges
   sequence s_idle;
      (!busy && bus_hold_ack_b) [*3];
   endsequence
   a_hold_floats: assert property (
      s_held |-> !mem_bus_oe && !wide_port_data_oe)
      else $error("memory outputs driven during hold");
   a_ack_after_idle: assert property (
      $fell(bus_hold_ack_b) |-> !$past(busy))
      else $error("hold granted while a transfer ran");
   a_hold_no_take: assert property (
      !bus_hold_ack_b |-> !req_ready)
      else $error("request taken during hold");
   a_hold_disable_blocks: assert property (
      $fell(bus_hold_ack_b) |-> !$past(glb.hold_disable))
      else $error("hold granted while disabled");
   a_disable_release: assert property (
      glb.hold_disable [*4] |-> bus_hold_ack_b)
      else $error("hold kept while disabled");
   a_clk_float: assert property (
      s_held |-> mem_out_clock_oe == ~glb.out_clock_hold_tristate)
      else $error("output clock enable wrong in hold");
   a_clk_runs: assert property (
      s_held ##0 !glb.out_clock_hold_tristate[0]
      |-> ##[1:16] $changed(mem_out_clock[0]))
      else $error("output clock one stopped in hold");
   a_idle_deselect: assert property (
      s_idle |-> &space_chip_enable_b)
      else $error("chip enable left low while idle");
   a_strap_take: assert property (
      $rose(rst_b) |=> boot_config == {narrow_port_addr_in[19:12],
      narrow_port_addr_in[10], narrow_port_addr_in[8:6]})
      else $error("boot straps captured wrongly");
endmodule

// File: bench/smp_sram_model.sv
// Behavioural synchronous SRAM standing on the wide data pins
module smp_sram_model (
   input wire logic clock,
   input wire logic sel_b,
   input wire logic strobe_b,
   input wire logic oe_b,
   input wire logic [19:0] addr,
   input wire logic [63:0] wdata,
   input wire logic wdata_oe,
   output logic [63:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] mem [16]; // Small store, low address bits only
   logic [3:0] cmd_addr = 4'h0; // Address of the last command
   logic [63:0] last = 64'h0; // Last value put on the lines
   logic [3:0] idx;
   // A command edge uses the fresh address, data edges the latched one
   assign idx = (!sel_b && !strobe_b) ? addr[3:0] : cmd_addr;
   // Released lines show a pattern that changes every cycle
   assign rdata = !oe_b ? mem[cmd_addr] : ~last;
   // Latch commands and store write data whenever the device drives
   always @(posedge clock) begin
      cmd_addr <= idx;
      last <= rdata;
      if (wdata_oe) begin
         mem[idx] <= wdata;
      end
   end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the synchronous memory port
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst_b = 1'b0, mem_in_clock = 1'b0;
   logic req_valid = 1'b0, hold_req_b = 1'b1;
   smp_pkg::smp_glb_ctrl_s glb;
   smp_pkg::smp_sec_ctrl_s [smp_pkg::SPACES-1:0] sec;
   smp_pkg::smp_req_s req;
   logic req_ready, rd_valid, bus_hold_ack_b, busy, wide_port_data_oe;
   logic mem_bus_oe, sync_address_strobe_b, sync_output_enable_b;
   logic sync_write_enable_b;
   logic [63:0] rd_data, wide_port_data_in, wide_port_data_out, q;
   logic [19:0] wide_port_addr, narrow_port_addr_in = 20'h5_a5c3;
   logic [7:0] wide_port_byte_en_b;
   logic [3:0] space_chip_enable_b;
   logic [1:0] mem_out_clock, mem_out_clock_oe;
   logic [11:0] boot_config;
   int fails = 0, compares = 0, bad, rises, cyc, wes;
   always #4 clock = ~clock;
   // Pin port clock, ten cycles a period
   always begin
      repeat (5) @(negedge clock);
      mem_in_clock = ~mem_in_clock;
   end
   smp_port dut_u (.clock, .rst_b, .glb, .sec, .mem_in_clock, .req_valid,
      .req, .req_ready, .rd_valid, .rd_data, .hold_req_b, .bus_hold_ack_b,
      .busy, .wide_port_data_in, .wide_port_data_out, .wide_port_data_oe,
      .wide_port_addr, .wide_port_byte_en_b, .space_chip_enable_b,
      .sync_address_strobe_b, .sync_output_enable_b, .sync_write_enable_b,
      .mem_bus_oe, .mem_out_clock, .mem_out_clock_oe, .narrow_port_addr_in,
      .boot_config);
   smp_sram_model sram_u (.clock, .sel_b(&space_chip_enable_b),
      .strobe_b(sync_address_strobe_b), .oe_b(sync_output_enable_b),
      .addr(wide_port_addr), .wdata(wide_port_data_out),
      .wdata_oe(wide_port_data_oe), .rdata(wide_port_data_in));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Print counts and the verdict, then stop
   task automatic results();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One access; counts selected clock rises and cycles until done
   task automatic access(input logic wr, input int sp, input logic [63:0] d);
      logic p, got;
      @(negedge clock);
      req = '{wr, sp[1:0], 20'h0_0004 + 20'(sp), 8'hff, d};
      req_valid = 1'b1;
      cyc = 0;
      while (req_ready !== 1'b1 && cyc < 200) begin
         @(negedge clock);
         cyc++;
      end
      check(64'(cyc < 200), 64'h1);
      req_valid = 1'b0;
      {bad, rises, cyc, wes, got, p} = '0;
      // Start from the level shown now, so a high phase is not a rise
      p = mem_out_clock[sec[sp].sync_clock_select];
      // Busy is registered, so always look at least one cycle on
      while ((cyc == 0 || busy !== 1'b0 || (!wr && !got)) && cyc < 300) begin
         @(negedge clock);
         cyc++;
         if (sync_write_enable_b === 1'b0) begin
            wes++;
         end
         // Byte enables must be active while the space is selected
         if (space_chip_enable_b[sp] === 1'b0 &&
            wide_port_byte_en_b !== 8'h00) begin
            bad++;
         end
         if (!got && mem_out_clock[sec[sp].sync_clock_select] && !p) begin
            rises++;
         end
         p = mem_out_clock[sec[sp].sync_clock_select];
         if (rd_valid === 1'b1 && !got) begin
            got = 1'b1;
            q = rd_data;
         end
         if (sec[sp].chip_enable_extend && sync_output_enable_b === 1'b0
            && space_chip_enable_b[sp] !== 1'b0) begin
            bad++;
         end
      end
      check(64'(cyc < 300), 64'h1);
   endtask
   // Cycles from now to the next rise of output clock one
   task automatic gap(output int n);
      logic p;
      n = 0;
      p = 1'b1;
      while (n < 64) begin
         @(negedge clock);
         n++;
         if (mem_out_clock[0] === 1'b1 && p === 1'b0) begin
            break;
         end
         p = mem_out_clock[0];
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Write then read each space, latencies and clocks differ by space
   task automatic t_latency();
      for (int i = 0; i < 4; i++) begin
         access(1'b1, i, 64'hfedc_ba98_7654_3210 ^ i);
         check(64'(wes != 0), 64'h1);
         check(64'(rises), 64'(7 - i));
         access(1'b0, i, 64'h0);
         check(q, 64'hfedc_ba98_7654_3210 ^ i);
         check(64'(rises), 64'(3 + i));
         check(64'(bad), 64'h0);
         check(64'(wes), 64'h0);
      end
      $display("test latency done");
   endtask
   // Strobe mode: deselect cycles only in address strobe mode
   task automatic t_mode();
      int c0;
      access(1'b0, 0, 64'h0);
      c0 = cyc;
      sec[0].read_enable_mode = 1'b1;
      access(1'b0, 0, 64'h0);
      check(64'(c0 > cyc), 64'h1);
      sec[0].read_enable_mode = 1'b0;
      $display("test mode done");
   endtask
   // Port clock from pin, divide by four and divide by six
   task automatic t_clksrc();
      int n;
      logic [1:0] src [3] = '{2'h0, 2'h1, 2'h2};
      int per [3] = '{20, 8, 12};
      for (int k = 0; k < 3; k++) begin
         glb.clk_src = src[k];
         repeat (30) @(negedge clock);
         gap(n);
         gap(n);
         check(64'(n), 64'(per[k]));
      end
      glb.clk_src = smp_pkg::CLK_SRC_DIV4;
      $display("test clock source done");
   endtask
   // Hold disabled, then granted, then requested mid transfer
   task automatic t_hold();
      int n;
      glb.hold_disable = 1'b1;
      hold_req_b = 1'b0;
      repeat (40) @(negedge clock);
      check(64'(bus_hold_ack_b), 64'h1);
      glb.hold_disable = 1'b0;
      repeat (40) @(negedge clock);
      check(64'(bus_hold_ack_b), 64'h0);
      check(64'(mem_out_clock_oe), 64'h1);
      check(64'(mem_bus_oe), 64'h0);
      hold_req_b = 1'b1;
      repeat (20) @(negedge clock);
      fork
         access(1'b0, 3, 64'h0);
         begin
            n = 0;
            while (req_ready !== 1'b1 && n < 200) begin
               @(negedge clock);
               n++;
            end
            hold_req_b = 1'b0;
         end
      join
      check(q, 64'hfedc_ba98_7654_3213);
      repeat (20) @(negedge clock);
      check(64'(bus_hold_ack_b), 64'h0);
      hold_req_b = 1'b1;
      repeat (20) @(negedge clock);
      $display("test hold done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      glb = '{2'h2, 1'b0, smp_pkg::CLK_SRC_DIV4};
      for (int i = 0; i < 4; i++) begin
         sec[i] = '{i[1:0], 2'(3 - i), i == 3, 1'b0, i[0]};
      end
      req = '0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      check(64'(boot_config), 64'h0_0000_0000_0000_05af);
      t_latency();
      t_mode();
      t_clksrc();
      t_hold();
      results();
   end
   // Watchdog against a hang
   initial begin
      #200000;
      fails++;
      results();
   end
endmodule
bind smp_port smp_port_monitor mon_u (.clock, .rst_b, .glb, .req_ready,
   .busy, .bus_hold_ack_b, .wide_port_data_oe, .space_chip_enable_b,
   .mem_bus_oe, .mem_out_clock, .mem_out_clock_oe, .narrow_port_addr_in,
   .boot_config);
